// ==== design/ioc_cond.sv ====
// One input channel: polarity, ON dead-time and one-shot pulse
`timescale 1ns/10ps
module ioc_cond #(
	parameter int ONE_SHOT_CYCLES = ioc_pkg::ONE_SHOT_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tick_ms,
	input wire logic raw,
	input ioc_pkg::ioc_chan_cfg_s cfg,
	output logic conditioned
);
	typedef enum logic [3:0] {
		IOC_IDLE = 4'h1,
		IOC_QUAL = 4'h2,
		IOC_ON = 4'h4,
		IOC_SPENT = 4'h8
	} ioc_cond_state_e;

	ioc_cond_state_e state;
	ioc_cond_state_e next_state;
	logic [ioc_pkg::DEAD_W-1:0] dead_cnt;
	logic [ioc_pkg::DEAD_W-1:0] next_dead_cnt;
	logic [ioc_pkg::PULSE_W-1:0] pulse_cnt;
	logic [ioc_pkg::PULSE_W-1:0] next_pulse_cnt;
	logic level;

	assign level = raw ^ cfg.invert;

	// Qualification and pulse sequencing
	always_comb begin
		next_state = state;
		next_dead_cnt = dead_cnt;
		next_pulse_cnt = pulse_cnt;
		unique case (state)
			IOC_IDLE: begin
				next_dead_cnt = '0;
				next_pulse_cnt = '0;
				if (level) begin
					next_state = (cfg.dead_ms == '0) ? IOC_ON : IOC_QUAL;
				end
			end
			IOC_QUAL: begin
				if (!level) begin
					next_state = IOC_IDLE;
				end else if (tick_ms) begin
					if (dead_cnt >= cfg.dead_ms) begin
						next_state = IOC_ON;
					end else begin
						next_dead_cnt = ioc_pkg::DEAD_W'(dead_cnt + 1'b1);
					end
				end
			end
			IOC_ON: begin
				if (!level) begin
					next_state = IOC_IDLE;
				end else if (cfg.one_shot) begin
					if (pulse_cnt == ioc_pkg::PULSE_W'(ONE_SHOT_CYCLES - 1)) begin
						next_state = IOC_SPENT;
					end else begin
						next_pulse_cnt = ioc_pkg::PULSE_W'(pulse_cnt + 1'b1);
					end
				end
			end
			IOC_SPENT: begin
				if (!level) begin
					next_state = IOC_IDLE;
				end
			end
		endcase
	end

	// Channel registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= IOC_IDLE;
			dead_cnt <= '0;
			pulse_cnt <= '0;
		end else begin
			state <= next_state;
			dead_cnt <= next_dead_cnt;
			pulse_cnt <= next_pulse_cnt;
		end
	end

	assign conditioned = (state == IOC_ON);
endmodule

// ==== design/ioc_pkg.sv ====
// Constants, field layouts and carrier types of the I/O signal conditioning block
package ioc_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 200;
	localparam int DEAD_TICK_MS = 1;
	localparam int ONE_SHOT_US = 250;
	localparam int MS_CYCLES = DEAD_TICK_MS * 1000 * CLK_MHZ;
	localparam int ONE_SHOT_CYCLES = ONE_SHOT_US * CLK_MHZ;
	localparam int MS_DIV_W = 18;
	localparam int PULSE_W = 16;

	// Channel counts and widths
	localparam int N_WIRED = 8;
	localparam int N_VIRT = 4;
	localparam int N_CHAN = N_WIRED + N_VIRT;
	localparam int N_USER = 2;
	localparam int SIG_W = 6;
	localparam int N_SIG = 64;
	localparam int FUNC_W = 5;
	localparam int N_FUNC = 32;
	localparam int DEAD_W = 8;
	localparam logic [DEAD_W-1:0] DEAD_MAX_MS = 8'hFA;

	// Register byte offsets
	localparam logic [7:0] REG_WIRED_FUNC_LO = 8'h00;
	localparam logic [7:0] REG_WIRED_FUNC_HI = 8'h04;
	localparam logic [7:0] REG_WIRED_COMP_LO = 8'h08;
	localparam logic [7:0] REG_WIRED_COMP_HI = 8'h0C;
	localparam logic [7:0] REG_VIRT_FUNC = 8'h10;
	localparam logic [7:0] REG_VIRT_SRC = 8'h14;
	localparam logic [7:0] REG_WIRED_CFG = 8'h18;
	localparam logic [7:0] REG_VIRT_CFG = 8'h1C;
	localparam logic [7:0] REG_USER_CFG0 = 8'h20;
	localparam logic [7:0] REG_USER_CFG1 = 8'h24;
	localparam logic [7:0] REG_CHAN_STATUS = 8'h28;
	localparam logic [7:0] REG_FUNC_STATUS = 8'h2C;

	// Field positions
	localparam int SEL_STRIDE = 8;
	localparam int CFG_DEAD_LSB = 0;
	localparam int CFG_INV_BIT = 8;
	localparam int CFG_ONESHOT_BIT = 9;
	localparam int UO_SRCA_LSB = 0;
	localparam int UO_INVA_BIT = 6;
	localparam int UO_SRCB_LSB = 8;
	localparam int UO_INVB_BIT = 14;
	localparam int UO_OP_BIT = 16;
	localparam int ST_VIRT_LSB = 8;
	localparam int ST_USER_LSB = 12;

	// Codes and reset values
	localparam logic [FUNC_W-1:0] FUNC_NONE = 5'h00;
	localparam logic [SIG_W-1:0] SIG_CONST_LOW = 6'h00;
	localparam logic OP_AND = 1'b0;
	localparam logic OP_OR = 1'b1;
	localparam logic [FUNC_W-1:0] RST_FUNC = FUNC_NONE;
	localparam logic [SIG_W-1:0] RST_SRC = SIG_CONST_LOW;
	localparam logic [DEAD_W-1:0] RST_DEAD = 8'h00;
	localparam logic RST_INV = 1'b0;
	localparam logic RST_ONESHOT = 1'b0;
	localparam logic RST_OP = OP_AND;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Conditioning settings shared by a group of inputs
	typedef struct packed {
		logic invert;
		logic one_shot;
		logic [DEAD_W-1:0] dead_ms;
	} ioc_chan_cfg_s;

	// Settings of one combined internal output
	typedef struct packed {
		logic [SIG_W-1:0] src_a;
		logic inv_a;
		logic [SIG_W-1:0] src_b;
		logic inv_b;
		logic op_or;
	} ioc_user_cfg_s;

	localparam ioc_chan_cfg_s RST_CHAN_CFG = '{RST_INV, RST_ONESHOT, RST_DEAD};
	localparam ioc_user_cfg_s RST_USER_CFG = '{RST_SRC, RST_INV, RST_SRC, RST_INV, RST_OP};
endpackage

// ==== design/ioc_tick.sv ====
// Millisecond timebase divider
`timescale 1ns/10ps
module ioc_tick #(
	parameter int MS_CYCLES = ioc_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	output logic tick_ms
);
	logic [ioc_pkg::MS_DIV_W-1:0] div_cnt;
	logic [ioc_pkg::MS_DIV_W-1:0] next_div_cnt;
	logic next_tick_ms;

	always_comb begin
		next_tick_ms = 1'b0;
		next_div_cnt = ioc_pkg::MS_DIV_W'(div_cnt + 1'b1);
		if (div_cnt == ioc_pkg::MS_DIV_W'(MS_CYCLES - 1)) begin
			next_div_cnt = '0;
			next_tick_ms = 1'b1;
		end
	end

	// Divider registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= '0;
			tick_ms <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			tick_ms <= next_tick_ms;
		end
	end
endmodule

// ==== design/ioc_top.sv ====
// Top of the I/O signal conditioning block with its AXI4-Lite register slave
`timescale 1ns/10ps
module ioc_top #(
	parameter int MS_CYCLES = ioc_pkg::MS_CYCLES,
	parameter int ONE_SHOT_CYCLES = ioc_pkg::ONE_SHOT_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ioc_pkg::N_WIRED-1:0] wired_inputs,
	input wire logic [ioc_pkg::N_SIG-2:0] internal_outputs,
	output logic [ioc_pkg::N_FUNC-1:0] asserted_functions,
	output logic [ioc_pkg::N_USER-1:0] combined_internal_output
);
	localparam int NW = ioc_pkg::N_WIRED;
	localparam int NV = ioc_pkg::N_VIRT;
	localparam int SS = ioc_pkg::SEL_STRIDE;

	// Configuration state
	logic [ioc_pkg::FUNC_W-1:0] wired_func [NW], next_wired_func [NW];
	logic [ioc_pkg::FUNC_W-1:0] wired_comp [NW], next_wired_comp [NW];
	logic [ioc_pkg::FUNC_W-1:0] virt_func [NV], next_virt_func [NV];
	logic [ioc_pkg::SIG_W-1:0] virt_src [NV], next_virt_src [NV];
	ioc_pkg::ioc_chan_cfg_s wired_cfg, next_wired_cfg;
	ioc_pkg::ioc_chan_cfg_s virt_cfg, next_virt_cfg;
	ioc_pkg::ioc_user_cfg_s user_cfg [ioc_pkg::N_USER], next_user_cfg [ioc_pkg::N_USER];

	// Bus state
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_bresp, next_rresp;
	logic do_write;
	logic [31:0] old_word;
	logic [31:0] merged;

	// Datapath signals
	logic tick_ms;
	logic [ioc_pkg::N_SIG-1:0] sig_set;
	logic [ioc_pkg::N_CHAN-1:0] chan_raw;
	logic [ioc_pkg::N_CHAN-1:0] chan_on;
	logic [ioc_pkg::N_FUNC-1:0] next_asserted;
	logic [ioc_pkg::N_USER-1:0] next_combined;

	// Word view of every register
	function automatic logic [31:0] reg_word(input logic [7:0] addr);
		logic [31:0] word;
		word = '0;
		case ({addr[7:2], 2'b00})
			ioc_pkg::REG_WIRED_FUNC_LO: for (int k = 0; k < 4; k++) word[SS*k +: 5] = wired_func[k];
			ioc_pkg::REG_WIRED_FUNC_HI: for (int k = 0; k < 4; k++) word[SS*k +: 5] = wired_func[k+4];
			ioc_pkg::REG_WIRED_COMP_LO: for (int k = 0; k < 4; k++) word[SS*k +: 5] = wired_comp[k];
			ioc_pkg::REG_WIRED_COMP_HI: for (int k = 0; k < 4; k++) word[SS*k +: 5] = wired_comp[k+4];
			ioc_pkg::REG_VIRT_FUNC: for (int k = 0; k < NV; k++) word[SS*k +: 5] = virt_func[k];
			ioc_pkg::REG_VIRT_SRC: for (int k = 0; k < NV; k++) word[SS*k +: 6] = virt_src[k];
			ioc_pkg::REG_WIRED_CFG: word = cfg_word(wired_cfg);
			ioc_pkg::REG_VIRT_CFG: word = cfg_word(virt_cfg);
			ioc_pkg::REG_USER_CFG0: word = user_word(user_cfg[0]);
			ioc_pkg::REG_USER_CFG1: word = user_word(user_cfg[1]);
			ioc_pkg::REG_CHAN_STATUS: begin
				word[ioc_pkg::CFG_DEAD_LSB +: NW] = chan_on[NW-1:0];
				word[ioc_pkg::ST_VIRT_LSB +: NV] = chan_on[ioc_pkg::N_CHAN-1:NW];
				word[ioc_pkg::ST_USER_LSB +: ioc_pkg::N_USER] = combined_internal_output;
			end
			ioc_pkg::REG_FUNC_STATUS: word = asserted_functions;
			default: word = '0;
		endcase
		return word;
	endfunction

	function automatic logic [31:0] cfg_word(input ioc_pkg::ioc_chan_cfg_s c);
		logic [31:0] word;
		word = '0;
		word[ioc_pkg::CFG_DEAD_LSB +: ioc_pkg::DEAD_W] = c.dead_ms;
		word[ioc_pkg::CFG_INV_BIT] = c.invert;
		word[ioc_pkg::CFG_ONESHOT_BIT] = c.one_shot;
		return word;
	endfunction

	function automatic logic [31:0] user_word(input ioc_pkg::ioc_user_cfg_s u);
		logic [31:0] word;
		word = '0;
		word[ioc_pkg::UO_SRCA_LSB +: ioc_pkg::SIG_W] = u.src_a;
		word[ioc_pkg::UO_INVA_BIT] = u.inv_a;
		word[ioc_pkg::UO_SRCB_LSB +: ioc_pkg::SIG_W] = u.src_b;
		word[ioc_pkg::UO_INVB_BIT] = u.inv_b;
		word[ioc_pkg::UO_OP_BIT] = u.op_or;
		return word;
	endfunction

	// Dead-time field, clamped to DEAD_MAX_MS (250 ms)
	function automatic ioc_pkg::ioc_chan_cfg_s cfg_from(input logic [31:0] w);
		ioc_pkg::ioc_chan_cfg_s c;
		logic [ioc_pkg::DEAD_W-1:0] d;
		d = w[ioc_pkg::CFG_DEAD_LSB +: ioc_pkg::DEAD_W];
		c.dead_ms = (d > ioc_pkg::DEAD_MAX_MS) ? ioc_pkg::DEAD_MAX_MS : d;
		c.invert = w[ioc_pkg::CFG_INV_BIT];
		c.one_shot = w[ioc_pkg::CFG_ONESHOT_BIT];
		return c;
	endfunction

	function automatic ioc_pkg::ioc_user_cfg_s user_from(input logic [31:0] w);
		ioc_pkg::ioc_user_cfg_s u;
		u.src_a = w[ioc_pkg::UO_SRCA_LSB +: ioc_pkg::SIG_W];
		u.inv_a = w[ioc_pkg::UO_INVA_BIT];
		u.src_b = w[ioc_pkg::UO_SRCB_LSB +: ioc_pkg::SIG_W];
		u.inv_b = w[ioc_pkg::UO_INVB_BIT];
		u.op_or = w[ioc_pkg::UO_OP_BIT];
		return u;
	endfunction

	function automatic logic writable(input logic [7:0] addr);
		logic [7:0] a;
		a = {addr[7:2], 2'b00};
		return (a <= ioc_pkg::REG_USER_CFG1);
	endfunction

	// Write happens once both address and data are held
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// Current word under the write address; follows every register it reads
	always_comb begin
		old_word = reg_word(aw_addr);
	end

	// Byte-lane merge of write data over the current word
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			merged[8*b +: 8] = w_strb[b] ? w_data[8*b +: 8] : old_word[8*b +: 8];
		end
	end

	// Next values of the AXI channels
	always_comb begin
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_awready = s_axi_awready;
		next_wready = s_axi_wready;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_addr = s_axi_awaddr;
			next_awready = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
			next_wready = 1'b0;
		end
		if (do_write) begin
			next_bvalid = 1'b1;
			next_bresp = writable(aw_addr) ? ioc_pkg::RESP_OKAY : ioc_pkg::RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = reg_word(s_axi_araddr);
			next_rresp = (s_axi_araddr[7:2] <= ioc_pkg::REG_FUNC_STATUS[7:2]) ?
				ioc_pkg::RESP_OKAY : ioc_pkg::RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	// Next values of the configuration registers
	always_comb begin
		next_wired_func = wired_func;
		next_wired_comp = wired_comp;
		next_virt_func = virt_func;
		next_virt_src = virt_src;
		next_wired_cfg = wired_cfg;
		next_virt_cfg = virt_cfg;
		next_user_cfg = user_cfg;
		if (do_write) begin
			case ({aw_addr[7:2], 2'b00})
				ioc_pkg::REG_WIRED_FUNC_LO: for (int k = 0; k < 4; k++) next_wired_func[k] = merged[SS*k +: 5];
				ioc_pkg::REG_WIRED_FUNC_HI: for (int k = 0; k < 4; k++) next_wired_func[k+4] = merged[SS*k +: 5];
				ioc_pkg::REG_WIRED_COMP_LO: for (int k = 0; k < 4; k++) next_wired_comp[k] = merged[SS*k +: 5];
				ioc_pkg::REG_WIRED_COMP_HI: for (int k = 0; k < 4; k++) next_wired_comp[k+4] = merged[SS*k +: 5];
				ioc_pkg::REG_VIRT_FUNC: for (int k = 0; k < NV; k++) next_virt_func[k] = merged[SS*k +: 5];
				ioc_pkg::REG_VIRT_SRC: for (int k = 0; k < NV; k++) next_virt_src[k] = merged[SS*k +: 6];
				ioc_pkg::REG_WIRED_CFG: next_wired_cfg = cfg_from(merged);
				ioc_pkg::REG_VIRT_CFG: next_virt_cfg = cfg_from(merged);
				ioc_pkg::REG_USER_CFG0: next_user_cfg[0] = user_from(merged);
				ioc_pkg::REG_USER_CFG1: next_user_cfg[1] = user_from(merged);
				default: next_virt_src = virt_src;
			endcase
		end
	end

	// Register state, reset to documented defaults
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ioc_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ioc_pkg::RESP_OKAY;
			wired_func <= '{default: ioc_pkg::RST_FUNC};
			wired_comp <= '{default: ioc_pkg::RST_FUNC};
			virt_func <= '{default: ioc_pkg::RST_FUNC};
			virt_src <= '{default: ioc_pkg::RST_SRC};
			wired_cfg <= ioc_pkg::RST_CHAN_CFG;
			virt_cfg <= ioc_pkg::RST_CHAN_CFG;
			user_cfg <= '{default: ioc_pkg::RST_USER_CFG};
		end else begin
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			wired_func <= next_wired_func;
			wired_comp <= next_wired_comp;
			virt_func <= next_virt_func;
			virt_src <= next_virt_src;
			wired_cfg <= next_wired_cfg;
			virt_cfg <= next_virt_cfg;
			user_cfg <= next_user_cfg;
		end
	end

	// Code zero of the signal set is the constant-low source
	assign sig_set = {internal_outputs, 1'b0};

	ioc_tick #(
		.MS_CYCLES(MS_CYCLES)
	) u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.tick_ms(tick_ms)
	);

	// One conditioner per wired and loopback input
	generate
		for (genvar i = 0; i < ioc_pkg::N_CHAN; i++) begin : g_chan
			if (i < NW) begin : g_wired
				assign chan_raw[i] = wired_inputs[i];
			end else begin : g_virt
				assign chan_raw[i] = sig_set[virt_src[i-NW]];
			end
			ioc_cond #(
				.ONE_SHOT_CYCLES(ONE_SHOT_CYCLES)
			) u_cond (
				.clk(clk),
				.reset_n(reset_n),
				.tick_ms(tick_ms),
				.raw(chan_raw[i]),
				.cfg((i < NW) ? wired_cfg : virt_cfg),
				.conditioned(chan_on[i])
			);
		end
	endgenerate

	// Function decode from conditioned inputs
	always_comb begin
		next_asserted = '0;
		for (int f = 1; f < ioc_pkg::N_FUNC; f++) begin
			for (int k = 0; k < NW; k++) begin
				if (chan_on[k] && (wired_func[k] == ioc_pkg::FUNC_W'(f) ||
					wired_comp[k] == ioc_pkg::FUNC_W'(f))) begin
					next_asserted[f] = 1'b1;
				end
			end
			for (int k = 0; k < NV; k++) begin
				if (chan_on[NW+k] && virt_func[k] == ioc_pkg::FUNC_W'(f)) begin
					next_asserted[f] = 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int u = 0; u < ioc_pkg::N_USER; u++) begin
			// select A, invert A, invert B, AND or OR
			if (user_cfg[u].op_or == ioc_pkg::OP_OR) begin
				next_combined[u] = (sig_set[user_cfg[u].src_a] ^ user_cfg[u].inv_a) |
					(sig_set[user_cfg[u].src_b] ^ user_cfg[u].inv_b);
			end else begin
				next_combined[u] = (sig_set[user_cfg[u].src_a] ^ user_cfg[u].inv_a) &
					(sig_set[user_cfg[u].src_b] ^ user_cfg[u].inv_b);
			end
		end
	end

	// Output registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			asserted_functions <= '0;
			combined_internal_output <= '0;
		end else begin
			asserted_functions <= next_asserted;
			combined_internal_output <= next_combined;
		end
	end
endmodule

// ==== verif/ioc_switches.sv ====
// Model of switches and sensors on the wired input lines
`timescale 1ns/10ps
module ioc_switches (
	input wire logic clk,
	input wire logic [7:0] target,
	input wire logic chatter,
	output logic [7:0] lines
);
	initial lines = 8'h00;
	// Contacts settle a cycle late and bounce while chatter is set
	always @(posedge clk) begin
		lines <= chatter ? (lines ^ target) : target;
	end
endmodule

// ==== verif/ioc_top_sva.sv ====
// Assertion checker for the I/O conditioning top
`timescale 1ns/10ps
module ioc_top_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ioc_pkg::N_SIG-2:0] internal_outputs,
	input wire logic [ioc_pkg::N_FUNC-1:0] asserted_functions,
	input wire logic [ioc_pkg::N_USER-1:0] combined_internal_output
);
	logic [2:0] since_wr;
	logic [2:0] next_since_wr;
	logic aw_w;
	assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Cycles since the last write address, saturating
	always_comb begin
		next_since_wr = (since_wr == 3'h7) ? since_wr : since_wr + 3'h1;
		if (s_axi_awvalid && s_axi_awready) next_since_wr = 3'h0;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) since_wr <= 3'h7;
		else since_wr <= next_since_wr;
	end
	a_func_none: assert property (asserted_functions[0] == 1'h0)
		else $error("function none asserted");
	a_wake_quiet: assert property ($rose(reset_n) |->
		asserted_functions == 32'h0 && combined_internal_output == 2'h0)
		else $error("outputs active after reset");
	a_user_cause: assert property ($changed(combined_internal_output) |->
		$past(internal_outputs) != $past(internal_outputs, 2) || since_wr < 3'h5)
		else $error("user output moved without cause");
	a_write_resp: assert property (aw_w |=> ##1 s_axi_bvalid)
		else $error("write response late");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2F |=>
		s_axi_rresp == ioc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_ro_err: assert property (aw_w && s_axi_awaddr[7:2] == 6'h0A |=> ##1
		s_axi_bresp == ioc_pkg::RESP_SLVERR)
		else $error("status write not refused");
	cover property (s_axi_rvalid && s_axi_rresp == ioc_pkg::RESP_SLVERR);
	cover property ($rose(combined_internal_output[0]));
	cover property ($rose(asserted_functions[5]));
endmodule
bind ioc_top ioc_top_sva i_ioc_top_sva (.*);

// ==== verif/testbench.sv ====
// Self-checking bench of the I/O conditioning block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("mismatch %0t got %h want %h", $time, a, b); end end
module testbench;
	logic clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, chatter;
	logic [7:0] s_axi_awaddr, s_axi_araddr, wired_inputs, sw;
	logic [31:0] s_axi_wdata, s_axi_rdata, asserted_functions, rd_data, c0, c1;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, combined_internal_output, resp;
	logic [62:0] internal_outputs;
	int fail_count, comparisons, seed, i;
	logic [31:0] shadow [64];
	ioc_top #(.MS_CYCLES(20), .ONE_SHOT_CYCLES(10)) i_ioc_top (.*);
	ioc_switches i_ioc_switches (.clk(clk), .target(sw), .chatter(chatter),
		.lines(wired_inputs));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task automatic wait_c(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Write one word, each channel released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		resp = s_axi_bresp;
		// Bench model of the register contents
		if (resp == ioc_pkg::RESP_OKAY) shadow[a[7:2]] = d;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		rd_data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// Reference of one combined output from its settings
	function automatic logic uo(input logic [31:0] c);
		logic a, b;
		a = (c[5:0] == 6'h00 ? 1'h0 : internal_outputs[c[5:0] - 6'h01]) ^ c[6];
		b = (c[13:8] == 6'h00 ? 1'h0 : internal_outputs[c[13:8] - 6'h01]) ^ c[14];
		return c[16] ? (a | b) : (a & b);
	endfunction
	task automatic trig(input int g, input logic lvl);
		if (g == 0) sw[0] <= lvl;
		else internal_outputs[2] <= lvl;
	endtask
	// Plain, inverted, dead-time and pulse behaviour of one input group
	task automatic grp(input int g);
		logic [7:0] ca;
		logic [31:0] ex;
		ca = (g != 0) ? 8'h1C : 8'h18;
		ex = (g != 0) ? 32'h80 : 32'h220;
		wr((g != 0) ? 8'h10 : 8'h00, (g != 0) ? 32'h7 : 32'h5);
		wr((g != 0) ? 8'h14 : 8'h08, (g != 0) ? 32'h3 : 32'h9);
		trig(g, 1'h1);
		wait_c(4);
		`CHK(asserted_functions, ex)
		trig(g, 1'h0);
		wait_c(4);
		`CHK(asserted_functions, 32'h0)
		wr(ca, 32'h100);
		wait_c(4);
		`CHK(asserted_functions, ex)
		wr(ca, 32'h2);
		chatter <= (g == 0);
		trig(g, 1'h1);
		wait_c(10);
		chatter <= 1'h0;
		wait_c((g != 0) ? 25 : 38);
		`CHK(asserted_functions, 32'h0)
		wait_c(30);
		`CHK(asserted_functions, ex)
		trig(g, 1'h0);
		// pulse mode only on a non-interlock function
		wr(ca, 32'h200);
		trig(g, 1'h1);
		wait_c(4);
		`CHK(asserted_functions, ex)
		wait_c(10);
		`CHK(asserted_functions, 32'h0)
		trig(g, 1'h0);
		wr(ca, 32'h0);
		$display("input group %0d test done", g);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		wait_c(20000);
		fail_count++;
		stop_test();
	end
	initial begin
		seed = 32'hf933;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sw, chatter} = 57'h0;
		s_axi_wstrb = 4'hF;
		internal_outputs = 63'h0;
		reset_n = 1'h0;
		wait_c(16);
		reset_n <= 1'h1;
		for (i = 0; i < 12; i++) begin
			rd(8'(i * 4));
			`CHK(rd_data, 32'h0)
		end
		rd(8'h30);
		`CHK(resp, ioc_pkg::RESP_SLVERR)
		wr(8'h28, 32'hFFFF);
		`CHK(resp, ioc_pkg::RESP_SLVERR)
		$display("reset and map test done");
		for (i = 0; i < 8; i++) begin
			c0 = ($random(seed) & 32'h7F7F) | (32'(i % 2) << 16);
			c1 = ($random(seed) & 32'h17F7F);
			wr(8'h20, c0);
			wr(8'h24, c1);
			internal_outputs <= {31'($random(seed)), 32'($random(seed))};
			wait_c(3);
			`CHK(combined_internal_output, {uo(c1), uo(c0)})
			rd(8'h20);
			`CHK(rd_data, shadow[8])
			rd(8'h24);
			`CHK(rd_data, shadow[9])
		end
		$display("user output test done");
		internal_outputs <= 63'h0;
		grp(0);
		grp(1);
		stop_test();
	end
endmodule
